// ==== aop_port.sv ====
// Result output port: 16-bit parallel, byte-wide parallel or dual serial.
// Assumes all pins are synchronous to clk and mode pins are static.
// Notes on behaviour
// RQ1: Parallel mode drives bus only when selected and reading
// RQ2: Byte mode sends each result in two reads
// RQ3: Byte mode uses low eight pins, MSB on seven
// RQ4: Serial mode puts two serial lines on pins seven, eight
// RQ5: High-byte-first input picks order of the two bytes
// RQ6: Interface and byte selects decode the three modes
// RQ7: Host grounds unused pins and byte order in serial
// RQ8: Reference select enables the internal reference
// RQ9: Select fall loads first bit, clock rise shifts
// RQ10: After both bytes, next read gives next channel
`timescale 1ns/1ps
`include "aop_defs.svh"
module aop_port #(
   parameter int CHANNELS = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic rd_sclk,
   input wire logic interface_select,
   input wire logic ref_select,
   input wire logic [`AOP_WORD_W-1:0] parallel_result_bus_i,
   input wire logic [CHANNELS-1:0][`AOP_WORD_W-1:0] result_words,
   input wire logic results_load,
   output logic [`AOP_WORD_W-1:0] parallel_result_bus_o,
   output logic [`AOP_WORD_W-1:0] parallel_result_bus_oe,
   output logic internal_ref_enable,
   output aop_pkg::aop_mode_e mode
);
   localparam int CW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
   localparam int HALF = CHANNELS / 2;
   localparam logic [CW-1:0] LAST_CH = CW'(CHANNELS - 1);

   logic cs_n_q;
   logic rd_q;
   logic [CW-1:0] chan;
   logic byte_phase;
   aop_pkg::aop_pins_s pins;
   aop_pkg::aop_pins_s next_pins;

   wire logic byte_mode_select;
   wire logic high_byte_first;
   wire logic cs_fall;
   wire logic rd_rise;
   wire logic read_act;
   wire logic is_par;
   wire logic is_byte;
   wire logic is_ser;
   wire logic [CW-1:0] next_chan;
   wire logic [`AOP_WORD_W-1:0] cur_word;
   wire logic [`AOP_BYTE_W-1:0] byte_out;
   wire logic ser_a;
   wire logic ser_b;

   // Mode straps share the upper data pins; only read while not driven
   assign byte_mode_select = parallel_result_bus_i[`AOP_BYTE_SEL_POS];
   assign high_byte_first = parallel_result_bus_i[`AOP_HBF_POS];
   assign mode = aop_pkg::aop_decode_mode(interface_select,
                                          byte_mode_select); // see RQ6
   assign is_par = (mode == aop_pkg::AOP_MODE_PAR16);
   assign is_byte = (mode == aop_pkg::AOP_MODE_BYTE);
   assign is_ser = (mode == aop_pkg::AOP_MODE_SERIAL);

   assign cs_fall = cs_n_q & ~cs_n;
   assign rd_rise = ~rd_q & rd_sclk & ~cs_n;
   assign read_act = ~cs_n & ~rd_sclk;
   assign next_chan = (chan == LAST_CH) ? '0 : CW'(chan + 1'b1);
   assign cur_word = result_words[chan];
   // First read gives the upper byte when high_byte_first is set
   assign byte_out = (high_byte_first ^ byte_phase) ?
                     cur_word[`AOP_WORD_W-1:`AOP_BYTE_W] :
                     cur_word[`AOP_BYTE_W-1:0]; // see RQ5

   assign parallel_result_bus_o = pins.data;
   assign parallel_result_bus_oe = pins.oe;

   always_comb begin
      next_pins.data = `AOP_WORD_RST;
      next_pins.oe = `AOP_OE_RST;
      unique case (mode)
         aop_pkg::AOP_MODE_PAR16: begin
            next_pins.data = cur_word;
            next_pins.oe = {`AOP_WORD_W{read_act}}; // see RQ1
         end
         aop_pkg::AOP_MODE_BYTE: begin
            next_pins.data = {{`AOP_BYTE_W{1'b0}}, byte_out}; // see RQ3
            next_pins.oe = {{`AOP_BYTE_W{1'b0}},
                            {`AOP_BYTE_W{read_act}}}; // see RQ2
         end
         aop_pkg::AOP_MODE_SERIAL: begin
            next_pins.data[`AOP_SER_A_POS] = ser_a; // see RQ4
            next_pins.data[`AOP_SER_B_POS] = ser_b;
            next_pins.oe[`AOP_SER_A_POS] = ~cs_n; // see RQ9
            next_pins.oe[`AOP_SER_B_POS] = ~cs_n;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cs_n_q <= 1'b1;
         rd_q <= 1'b1;
         pins <= '0;
         internal_ref_enable <= 1'b0;
      end else begin
         cs_n_q <= cs_n;
         rd_q <= rd_sclk;
         pins <= next_pins;
         internal_ref_enable <= ref_select; // see RQ8
      end
   end

   // A new conversion restarts the parallel and byte readout at the first channel
   always_ff @(posedge clk) begin
      if (reset || results_load) begin
         chan <= '0;
         byte_phase <= 1'b0;
      end else if (rd_rise && is_par) begin
         chan <= next_chan;
      end else if (rd_rise && is_byte) begin
         byte_phase <= ~byte_phase; // see RQ2
         if (byte_phase)
            chan <= next_chan; // see RQ10
      end
   end

   aop_serial_line #(
      .WORDS(HALF)
   ) u_line_a (
      .clk(clk),
      .reset(reset),
      .load(cs_fall && is_ser),
      .shift(rd_rise && is_ser),
      .words(result_words[HALF-1:0]),
      .serial_bit(ser_a)
   );

   aop_serial_line #(
      .WORDS(CHANNELS - HALF)
   ) u_line_b (
      .clk(clk),
      .reset(reset),
      .load(cs_fall && is_ser),
      .shift(rd_rise && is_ser),
      .words(result_words[CHANNELS-1:HALF]),
      .serial_bit(ser_b)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_par_drive_gate: assert property ( // see RQ1
      $past(is_par) ##0 !$past(reset) |->
      (parallel_result_bus_oe == {`AOP_WORD_W{$past(read_act)}}))
      else $error("parallel bus enable not tied to select and read");

   a_byte_two_reads: assert property ( // see RQ2
      is_byte && rd_rise && !byte_phase && !results_load |=>
      chan == $past(chan) && byte_phase)
      else $error("byte mode moved channel after first read");

   a_byte_advance: assert property ( // see RQ10
      is_byte && rd_rise && byte_phase && !results_load |=>
      chan == $past(next_chan) && !byte_phase)
      else $error("byte mode did not advance after second read");

   a_byte_lanes: assert property ( // see RQ3
      is_byte |=> parallel_result_bus_oe[15:8] == 8'h00
      && parallel_result_bus_o[15:8] == 8'h00)
      else $error("byte mode touched upper pins");

   a_byte_order: assert property ( // see RQ5
      is_byte && !byte_phase && high_byte_first |=>
      parallel_result_bus_o[7:0] == $past(cur_word[15:8]))
      else $error("high byte not first when requested");

   a_serial_lines: assert property ( // see RQ4
      is_ser |=> parallel_result_bus_oe[15:9] == 7'h00
      && parallel_result_bus_oe[6:0] == 7'h00)
      else $error("serial mode drives unused pins");

   a_mode_decode: assert property ( // see RQ6
      interface_select |-> mode != aop_pkg::AOP_MODE_PAR16)
      else $error("interface select high gave parallel mode");

   a_ref_follow: assert property ( // see RQ8
      ref_select [*2] |-> ##1 internal_ref_enable)
      else $error("internal reference not enabled");

   a_serial_release: assert property ( // see RQ9
      is_ser && cs_fall ##1 (is_ser && !cs_n) [*1] |=>
      parallel_result_bus_oe[7] && parallel_result_bus_oe[8]
      && parallel_result_bus_o[7] == $past(result_words[0][15], 2))
      else $error("serial select fall did not present first bit");

   c_par_read: cover property (is_par && read_act ##1 rd_rise);
   c_byte_pair: cover property (is_byte && rd_rise && byte_phase);
   c_serial_frame: cover property (is_ser && cs_fall ##[1:40] rd_rise);
endmodule

// ==== aop_defs.svh ====
// Constants for the converter result output port.
// Included by the package and the design modules, definitions only.
`ifndef AOP_DEFS_SVH
`define AOP_DEFS_SVH
`define AOP_WORD_W 16
`define AOP_BYTE_W 8
`define AOP_BIT_CNT_W 4
`define AOP_LAST_BIT 4'hF
`define AOP_SER_A_POS 7
`define AOP_SER_B_POS 8
`define AOP_BYTE_SEL_POS 15
`define AOP_HBF_POS 14
`define AOP_WORD_RST 16'h0000
`define AOP_OE_RST 16'h0000
`endif

// ==== aop_pkg.sv ====
// Types and mode decode for the converter result output port.
// Assumes the constants header is on the include path.
`include "aop_defs.svh"
package aop_pkg;
   typedef enum logic [1:0] {
      AOP_MODE_PAR16,
      AOP_MODE_SERIAL,
      AOP_MODE_BYTE
   } aop_mode_e;

   typedef struct packed {
      logic [`AOP_WORD_W-1:0] data;
      logic [`AOP_WORD_W-1:0] oe;
   } aop_pins_s;

   function automatic aop_mode_e aop_decode_mode(input logic if_sel,
                                                 input logic byte_sel);
      if (!if_sel)
         return AOP_MODE_PAR16;
      else if (byte_sel)
         return AOP_MODE_BYTE;
      else
         return AOP_MODE_SERIAL;
   endfunction
endpackage

// ==== aop_serial_line.sv ====
// One serial output line: shifts a run of 16-bit words out MSB first.
// Assumes load and shift are one-cycle pulses from the owning port.
`timescale 1ns/1ps
`include "aop_defs.svh"
module aop_serial_line #(
   parameter int WORDS = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic shift,
   input wire logic [WORDS-1:0][`AOP_WORD_W-1:0] words,
   output logic serial_bit
);
   localparam int IW = (WORDS > 1) ? $clog2(WORDS) : 1;
   localparam logic [IW-1:0] LAST_IDX = IW'(WORDS - 1);

   logic [`AOP_WORD_W-1:0] shreg;
   logic [`AOP_BIT_CNT_W-1:0] bit_cnt;
   logic [IW-1:0] idx;
   wire logic [IW-1:0] next_idx;
   wire logic word_done;

   // Wrap so a host clocking past the last word never indexes off the end
   assign next_idx = (idx == LAST_IDX) ? '0 : IW'(idx + 1'b1);
   assign word_done = (bit_cnt == `AOP_LAST_BIT);
   assign serial_bit = shreg[`AOP_WORD_W-1];

   always_ff @(posedge clk) begin
      if (reset) begin
         shreg <= `AOP_WORD_RST;
         bit_cnt <= '0;
         idx <= '0;
      end else if (load) begin
         shreg <= words[0]; // see RQ9
         bit_cnt <= '0;
         idx <= '0;
      end else if (shift) begin
         if (word_done) begin
            shreg <= words[next_idx];
            idx <= next_idx;
            bit_cnt <= '0;
         end else begin
            shreg <= {shreg[`AOP_WORD_W-2:0], 1'b0}; // see RQ9
            bit_cnt <= `AOP_BIT_CNT_W'(bit_cnt + 1'b1);
         end
      end
   end

   a_shift_next_bit: assert property (@(posedge clk) disable iff (reset)
      shift && !load && !word_done |=> serial_bit == $past(shreg[14]))
      else $error("serial line did not advance one bit"); // see RQ9
endmodule

// ==== aop_host_model.sv ====
// Host model that reads results by strobe or by serial clock.
// Assumes clk is shared with the port and the bench sets the straps.
`timescale 1ns/1ps
module aop_host_model (
   input wire logic clk,
   input wire logic byte_sel,
   input wire logic hbf,
   input wire logic [15:0] pin_o,
   input wire logic [15:0] pin_oe,
   output logic cs_n,
   output logic rd_sclk,
   output logic [15:0] pin_i
);
   // Wire level; unused pins grounded, straps on the top two
   assign pin_i = (pin_o & pin_oe)
                  | (~pin_oe & {byte_sel, hbf, 14'h0000});
   initial begin
      cs_n = 1'b1;
      rd_sclk = 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Strobe read; rd rises while selected so the channel advances
   task automatic rd(output logic [15:0] d, oe, output logic ok);
      ok = 1'b0;
      cs_n = 1'b0;
      rd_sclk = 1'b0;
      for (int i = 0; i < 8 && !ok; i++) begin
         step(1);
         ok = (pin_oe !== 16'h0000);
      end
      d = pin_o;
      oe = pin_oe;
      rd_sclk = 1'b1;
      step(2);
      cs_n = 1'b1;
      step(2);
   endtask
   // Serial frame; clock pulses while deselected must be ignored
   task automatic ser(output logic [31:0] a, b, output logic [15:0] oe0, oe);
      repeat (2) begin
         rd_sclk = 1'b1;
         step(2);
         rd_sclk = 1'b0;
         step(2);
      end
      oe0 = pin_oe;
      cs_n = 1'b0;
      step(4);
      oe = pin_oe;
      for (int i = 31; i >= 0; i--) begin
         a[i] = pin_o[7];
         b[i] = pin_o[8];
         rd_sclk = 1'b1;
         step(2);
         rd_sclk = 1'b0;
         step(2);
      end
      cs_n = 1'b1;
      step(2);
   endtask
endmodule

// ==== tb_adc_result_output_port.sv ====
// Self-checking bench for the result output port, four channels.
// Assumes the host model drives select, strobe and the pin levels.
`timescale 1ns/1ps
module tb_adc_result_output_port;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic if_sel = 1'b0;
   logic ref_select = 1'b0;
   logic byte_sel = 1'b0;
   logic hbf = 1'b0;
   logic load = 1'b0;
   logic [3:0][15:0] w = {16'h1E2D, 16'h3C4B, 16'h5A69, 16'h8796};
   logic cs_n, rd_sclk, ref_en;
   logic [15:0] pin_i, pin_o, pin_oe;
   aop_pkg::aop_mode_e mode;
   int n_mismatch = 0;
   int cmp_count = 0;
   always #4 clk = ~clk;
   aop_port #(.CHANNELS(4)) dut (.clk(clk), .reset(reset), .cs_n(cs_n),
      .rd_sclk(rd_sclk), .interface_select(if_sel), .ref_select(ref_select),
      .parallel_result_bus_i(pin_i), .result_words(w), .results_load(load),
      .parallel_result_bus_o(pin_o), .parallel_result_bus_oe(pin_oe),
      .internal_ref_enable(ref_en), .mode(mode));
   aop_host_model host (.clk(clk), .byte_sel(byte_sel), .hbf(hbf),
      .pin_o(pin_o), .pin_oe(pin_oe), .cs_n(cs_n), .rd_sclk(rd_sclk),
      .pin_i(pin_i));
   task automatic wrap_up;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [15:0] ed, eo);
      logic [15:0] d, oe;
      logic ok;
      host.rd(d, oe, ok);
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: no read answer", $time);
         wrap_up();
      end else begin
         chk(d, ed);
         chk(oe, eo);
      end
   endtask
   task automatic pulse_load;
      load = 1'b1;
      host.step(1);
      load = 1'b0;
      host.step(1);
   endtask
   task automatic t_ref_mode;
      logic [1:0] e;
      ref_select = 1'b1;
      host.step(2);
      chk({15'h0000, ref_en}, 16'h0001);
      ref_select = 1'b0;
      host.step(2);
      chk({15'h0000, ref_en}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         if_sel = i[1];
         byte_sel = i[0];
         e = !i[1] ? aop_pkg::AOP_MODE_PAR16 :
             i[0] ? aop_pkg::AOP_MODE_BYTE : aop_pkg::AOP_MODE_SERIAL;
         host.step(1);
         chk({14'h0000, mode}, {14'h0000, e});
      end
   endtask
   task automatic t_par;
      if_sel = 1'b0;
      byte_sel = 1'b0;
      pulse_load();
      host.rd_sclk = 1'b0;
      host.step(3);
      chk(pin_oe, 16'h0000);
      host.rd_sclk = 1'b1;
      host.step(2);
      for (int i = 0; i < 5; i++)
         rd_chk(w[i % 4], 16'hFFFF);
   endtask
   task automatic t_byte(input logic h);
      logic [7:0] f, s;
      if_sel = 1'b1;
      byte_sel = 1'b1;
      hbf = h;
      pulse_load();
      for (int i = 0; i < 7; i++) begin
         f = h ? w[(i / 2) % 4][15:8] : w[(i / 2) % 4][7:0];
         s = h ? w[(i / 2) % 4][7:0] : w[(i / 2) % 4][15:8];
         rd_chk({8'h00, i % 2 ? s : f}, 16'h00FF);
      end
      // Odd byte left over; a new result set restarts the pair
      w[0] = ~w[0];
      pulse_load();
      rd_chk({8'h00, h ? w[0][15:8] : w[0][7:0]}, 16'h00FF);
   endtask
   task automatic t_ser;
      logic [31:0] a, b;
      logic [15:0] oe0, oe;
      if_sel = 1'b1;
      byte_sel = 1'b0;
      hbf = 1'b0;
      pulse_load();
      host.ser(a, b, oe0, oe);
      chk(oe0, 16'h0000);
      chk(oe, 16'h0180);
      chk(a[31:16], w[0]);
      chk(a[15:0], w[1]);
      chk(b[31:16], w[2]);
      chk(b[15:0], w[3]);
   endtask
   // Reset between reads must clear the byte phase and the pins
   task automatic t_reset;
      if_sel = 1'b1;
      byte_sel = 1'b1;
      hbf = 1'b1;
      ref_select = 1'b1;
      pulse_load();
      rd_chk({8'h00, w[0][15:8]}, 16'h00FF);
      reset = 1'b1;
      host.step(1);
      chk(pin_o, 16'h0000);
      chk(pin_oe, 16'h0000);
      chk({15'h0000, ref_en}, 16'h0000);
      reset = 1'b0;
      host.step(1);
      chk({15'h0000, ref_en}, 16'h0001);
      rd_chk({8'h00, w[0][15:8]}, 16'h00FF);
      ref_select = 1'b0;
   endtask
   initial begin
      host.step(3);
      reset = 1'b0;
      host.step(1);
      t_ref_mode();
      t_par();
      t_byte(1'b1);
      t_byte(1'b0);
      t_ser();
      t_reset();
      wrap_up();
   end
endmodule
